/* emf_mac_framing.sv */
// Purpose: transmit and receive framing of a mac towards an internal phy
// Assumes: all inputs synchronous to ref_clk; phy samples the link on tick
// Notes:   link nibbles change once every four ref_clk cycles
`timescale 1ns/1ns
`default_nettype none

module emf_mac_framing (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // transmit byte stream from the mac client
  input  wire logic                tx_valid,
  input  wire logic [7:0]          tx_data,
  input  wire logic                tx_last,
  input  wire logic                pad_enable,
  output logic                     tx_ready,
  output logic                     tx_underrun,
  // nibble link to the phy
  output logic [3:0]               mii_txd,
  output logic                     mii_tx_en,
  input  wire logic [3:0]          mii_rxd,
  input  wire logic                mii_rx_dv,
  // receive byte stream to the mac client
  output logic                     rx_valid,
  output logic [7:0]               rx_data,
  output logic                     rx_first,
  output logic                     rx_group,
  output logic                     rx_done,
  output logic                     rx_crc_ok,
  // indicator pin multiplexer
  input  wire logic [1:0]          alternate_function_select,
  input  wire logic [1:0]          gpio_out,
  output logic                     activity_indicator_0,
  output logic                     activity_indicator_1
);
  import emf_pkg::*;

  typedef struct packed {
    logic [1:0]    div;
    emf_tx_state_t tx_state;
    logic          tx_half;
    logic [2:0]    tx_cnt;
    logic [10:0]   tx_octets;
    logic [7:0]    tx_byte;
    logic          tx_byte_last;
    logic [7:0]    hold;
    logic          hold_last;
    logic          hold_full;
    logic          seen_last;
    logic [31:0]   tx_crc;
    logic          tx_ready;
    logic          tx_underrun;
    logic [3:0]    mii_txd;
    logic          mii_tx_en;
    emf_rx_state_t rx_state;
    logic          rx_half;
    logic [3:0]    rx_low;
    logic          rx_first_pend;
    logic [31:0]   rx_crc;
    logic          rx_valid;
    logic [7:0]    rx_data;
    logic          rx_first;
    logic          rx_group;
    logic          rx_done;
    logic          rx_crc_ok;
    logic          ind0;
    logic          ind1;
  } emf_state_t;

  emf_state_t s;
  emf_state_t next_s;
  logic       tick;

  // one crc step over four bits, lsb first
  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // selects the nibble of a byte for the current half, low half first
  function automatic logic [3:0] pick(input logic [7:0] b, input logic hi);
    return hi ? b[7:4] : b[3:0];
  endfunction

  assign tick = (s.div == TICK_LAST);

  // next-state logic for divider, transmitter, receiver and pin multiplexer
  always_comb begin
    next_s = s;
    next_s.div = s.div + 2'h1;
    next_s.tx_underrun = 1'b0;
    next_s.rx_valid = 1'b0;
    next_s.rx_first = 1'b0;
    next_s.rx_done = 1'b0;

    // client hand-off into the holding register
    if (tx_valid && s.tx_ready) begin
      next_s.hold = tx_data;
      next_s.hold_last = tx_last;
      next_s.hold_full = 1'b1;
      next_s.seen_last = tx_last;
    end

    // transmitter advances one nibble per tick
    if (tick) begin
      unique case (s.tx_state)
        EMF_TX_IDLE: begin
          next_s.mii_tx_en = 1'b0;
          next_s.mii_txd = 4'h0;
          if (s.hold_full) begin
            next_s.tx_state = EMF_TX_PRE;
            next_s.tx_cnt = 3'h0;
            next_s.tx_half = 1'b0;
            next_s.tx_crc = CRC_INIT;
          end
        end
        EMF_TX_PRE: begin
          next_s.mii_tx_en = 1'b1;
          next_s.mii_txd = pick(PREAMBLE_BYTE, s.tx_half);
          next_s.tx_half = ~s.tx_half;
          if (s.tx_half) begin
            next_s.tx_cnt = s.tx_cnt + 3'h1;
            if (s.tx_cnt == PREAMBLE_LAST) begin
              next_s.tx_state = EMF_TX_SFD;
            end
          end
        end
        EMF_TX_SFD: begin
          next_s.mii_txd = pick(SFD_BYTE, s.tx_half);
          next_s.tx_half = ~s.tx_half;
          if (s.tx_half) begin
            next_s.tx_state = EMF_TX_BODY;
            next_s.tx_byte = s.hold;
            next_s.tx_byte_last = s.hold_last;
            next_s.hold_full = 1'b0;
            next_s.tx_octets = 11'h1;
          end
        end
        EMF_TX_BODY: begin
          next_s.mii_txd = pick(s.tx_byte, s.tx_half);
          next_s.tx_crc = crc_nib(s.tx_crc, pick(s.tx_byte, s.tx_half));
          next_s.tx_half = ~s.tx_half;
          if (s.tx_half) begin
            if (s.tx_byte_last) begin
              if (pad_enable && s.tx_octets < MIN_BODY) begin
                next_s.tx_state = EMF_TX_PAD;
              end else begin
                next_s.tx_state = EMF_TX_FCS;
                next_s.tx_cnt = 3'h0;
              end
            end else if (s.hold_full) begin
              next_s.tx_byte = s.hold;
              next_s.tx_byte_last = s.hold_last;
              next_s.hold_full = 1'b0;
              next_s.tx_octets = s.tx_octets + 11'h1;
            end else begin
              next_s.tx_state = EMF_TX_IDLE; // client ran dry: frame is cut short
              next_s.tx_underrun = 1'b1;
              next_s.seen_last = 1'b0;
            end
          end
        end
        EMF_TX_PAD: begin
          next_s.mii_txd = 4'h0;
          next_s.tx_crc = crc_nib(s.tx_crc, 4'h0);
          next_s.tx_half = ~s.tx_half;
          if (s.tx_half) begin
            next_s.tx_octets = s.tx_octets + 11'h1;
            if (s.tx_octets + 11'h1 >= MIN_BODY) begin
              next_s.tx_state = EMF_TX_FCS;
              next_s.tx_cnt = 3'h0;
            end
          end
        end
        EMF_TX_FCS: begin
          next_s.mii_txd = ~s.tx_crc[3:0];
          next_s.tx_crc = s.tx_crc >> 4;
          next_s.tx_cnt = s.tx_cnt + 3'h1;
          if (s.tx_cnt == FCS_LAST_NIB) begin
            next_s.tx_state = EMF_TX_IDLE;
            next_s.seen_last = 1'b0;
          end
        end
        default: begin
          next_s.tx_state = EMF_TX_IDLE;
        end
      endcase
    end
    next_s.tx_ready = ~next_s.hold_full & ~next_s.seen_last;

    // receiver samples the phy nibble on each tick
    if (tick) begin
      unique case (s.rx_state)
        EMF_RX_HUNT: begin
          if (mii_rx_dv && mii_rxd == PRE_NIBBLE) begin
            next_s.rx_state = EMF_RX_PRE;
          end
        end
        EMF_RX_PRE: begin
          if (!mii_rx_dv) begin
            next_s.rx_state = EMF_RX_HUNT;
          end else if (mii_rxd == SFD_HI_NIBBLE) begin
            next_s.rx_state = EMF_RX_DATA;
            next_s.rx_half = 1'b0;
            next_s.rx_first_pend = 1'b1;
            next_s.rx_crc = CRC_INIT;
          end else if (mii_rxd != PRE_NIBBLE) begin
            next_s.rx_state = EMF_RX_HUNT;
          end
        end
        EMF_RX_DATA: begin
          if (mii_rx_dv) begin
            next_s.rx_crc = crc_nib(s.rx_crc, mii_rxd);
            next_s.rx_half = ~s.rx_half;
            if (!s.rx_half) begin
              next_s.rx_low = mii_rxd;
            end else begin
              next_s.rx_valid = 1'b1;
              next_s.rx_data = {mii_rxd, s.rx_low};
              next_s.rx_first = s.rx_first_pend;
              next_s.rx_first_pend = 1'b0;
              if (s.rx_first_pend) begin
                next_s.rx_group = s.rx_low[0];
              end
            end
          end else begin
            next_s.rx_state = EMF_RX_HUNT;
            next_s.rx_done = 1'b1;
            next_s.rx_crc_ok = (s.rx_crc == CRC_RESIDUE) && !s.rx_half;
          end
        end
        default: begin
          next_s.rx_state = EMF_RX_HUNT;
        end
      endcase
    end

    // indicator pins: gpio until the select bit routes activity to them
    next_s.ind0 = alternate_function_select[0] ? next_s.mii_tx_en : gpio_out[0];
    next_s.ind1 = alternate_function_select[1] ? (next_s.rx_state == EMF_RX_DATA)
                                               : gpio_out[1];
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{div: 2'h0, tx_state: EMF_TX_IDLE, tx_crc: CRC_INIT, rx_state: EMF_RX_HUNT,
             rx_crc: CRC_INIT, ind0: IND_RESET[0], ind1: IND_RESET[1], default: '0};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register; link only towards the phy
  assign tx_ready             = s.tx_ready;
  assign tx_underrun          = s.tx_underrun;
  assign mii_txd              = s.mii_txd;
  assign mii_tx_en            = s.mii_tx_en;
  assign rx_valid             = s.rx_valid;
  assign rx_data              = s.rx_data;
  assign rx_first             = s.rx_first;
  assign rx_group             = s.rx_group;
  assign rx_done              = s.rx_done;
  assign rx_crc_ok            = s.rx_crc_ok;
  assign activity_indicator_0 = s.ind0;
  assign activity_indicator_1 = s.ind1;
endmodule // emf_mac_framing

`default_nettype wire

/* emf_mac_framing_properties.sv */
// Purpose: concurrent checks on the framing block ports
// Assumes: one clock domain, asynchronous active low reset
// Notes:   link nibbles are expected to hold four ref_clk cycles
`timescale 1ns/1ns
`default_nettype none
module emf_mac_framing_props
  import emf_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // client and link
  input wire logic       tx_valid,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       tx_underrun,
  input wire logic [3:0] mii_txd,
  input wire logic       mii_tx_en,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       rx_first,
  input wire logic       rx_group,
  // indicator pins
  input wire logic [1:0] alternate_function_select,
  input wire logic [1:0] gpio_out,
  input wire logic       activity_indicator_0,
  input wire logic       activity_indicator_1
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // pin multiplexer follows gpio unless selected
  chk_ind0_gpio: assert property ($past(reset_n) && !$past(alternate_function_select[0])
    |-> activity_indicator_0 == $past(gpio_out[0])) else $error("ind0 gpio");
  chk_ind1_gpio: assert property ($past(reset_n) && !$past(alternate_function_select[1])
    |-> activity_indicator_1 == $past(gpio_out[1])) else $error("ind1 gpio");
  chk_ind0_routed: assert property (alternate_function_select[0] && $stable(mii_tx_en)
    && $past(alternate_function_select[0]) |-> activity_indicator_0 == mii_tx_en)
    else $error("ind0 routed");
  chk_ind1_routed: assert property (alternate_function_select[1] && rx_valid
    && $past(alternate_function_select[1]) |-> activity_indicator_1)
    else $error("ind1 routed");
  // link timing and frame start
  chk_nibble_hold: assert property ($changed(mii_txd) |=> $stable(mii_txd)[*3])
    else $error("nibble hold");
  chk_pre_first: assert property ($rose(mii_tx_en) |-> mii_txd == PRE_NIBBLE)
    else $error("preamble first");
  chk_pre_len: assert property ($rose(mii_tx_en) |->
    ##52 (mii_txd == PRE_NIBBLE)[*8] ##1 (mii_txd == SFD_HI_NIBBLE)[*4])
    else $error("preamble length");
  chk_ready_last: assert property (tx_valid && tx_ready && tx_last |=> !tx_ready[*8])
    else $error("ready after last");
  // receive stream
  chk_rx_first: assert property (rx_first |-> rx_valid) else $error("rx first");
  chk_rx_spacing: assert property (rx_valid |=> !rx_valid[*7])
    else $error("rx spacing");
  chk_rx_group: assert property (rx_first |=> rx_group == $past(rx_data[0]))
    else $error("rx group");
  cov_tx: cover property ($rose(mii_tx_en));
  cov_under: cover property (tx_underrun);
  cov_rx: cover property (rx_first);
  cov_ind: cover property (alternate_function_select[0] && activity_indicator_0);
endmodule // emf_mac_framing_props
bind emf_mac_framing emf_mac_framing_props emf_mac_framing_props_i (.*);
`default_nettype wire

/* emf_mac_framing_tb.sv */
// Purpose: self-checking bench for the framing block
// Assumes: inputs change on the falling edge of ref_clk
// Notes:   sent frames are judged nibble by nibble, received frames byte by byte, against a local crc
`timescale 1ns/1ns
`default_nettype none
module emf_mac_framing_tb;
  import emf_pkg::*;
  logic ref_clk, reset_n, tx_valid, tx_last, pad_enable, tx_ready, tx_underrun;
  logic [7:0] tx_data, rx_data, rxq[$];
  logic [3:0] mii_txd, mii_rxd;
  logic mii_tx_en, mii_rx_dv, rx_valid, rx_first, rx_group, rx_done, rx_crc_ok, crc_seen;
  logic [1:0] alternate_function_select, gpio_out;
  logic activity_indicator_0, activity_indicator_1;
  int error_cnt, total_checks, done_cnt, first_at, cyc, und_cnt;
  emf_mac_framing emf_mac_framing_i (.*);
  emf_phy_model emf_phy_model_i (.*);
  // clock
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // receive monitor and hang guard
  always @(negedge ref_clk) begin
    if (tx_underrun) und_cnt++;
    if (rx_valid && rx_first) first_at = rxq.size();
    if (rx_valid) rxq.push_back(rx_data);
    if (rx_done) crc_seen = rx_crc_ok;
    if (rx_done) done_cnt++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] n);
    c = c ^ {28'h000_0000, n};
    for (int k = 0; k < 4; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction
  task automatic t_ind();
    repeat (3) @(negedge ref_clk);
    check("ind0 gpio", 0, activity_indicator_0);
    check("ind1 gpio", 1, activity_indicator_1);
    alternate_function_select = 2'h3;
    gpio_out = 2'h3;
    repeat (3) @(negedge ref_clk);
    check("ind0 routed", 0, activity_indicator_0);
    check("ind1 routed", 0, activity_indicator_1);
  endtask
  task automatic t_tx(input int n, input logic pd, input logic cut);
    logic [7:0] b[$];
    logic [3:0] e[$];
    logic [31:0] c;
    int w, u0;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) b.push_back(8'(i * 7 + 1));
    // a cut frame has no last marker, so it gets neither pad nor check sequence
    while (pd && !cut && b.size() < MIN_BODY) b.push_back(8'h00);
    for (int i = 0; i < 15; i++) e.push_back(PRE_NIBBLE);
    e.push_back(SFD_HI_NIBBLE);
    foreach (b[i]) begin
      e.push_back(b[i][3:0]);
      e.push_back(b[i][7:4]);
      c = crc_nib(crc_nib(c, b[i][3:0]), b[i][7:4]);
    end
    for (int j = 0; j < 8; j++) begin
      if (!cut) e.push_back(~c[4*j+:4]);
    end
    emf_phy_model_i.txq.delete();
    pad_enable = pd;
    u0 = und_cnt;
    // ready is judged mid-cycle, then the byte is held across the taking edge
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      tx_valid = 1'h1;
      tx_data = b[i];
      tx_last = (i == n - 1) && !cut;
      w = 0;
      while (tx_ready !== 1'h1 && w < 200) begin
        @(negedge ref_clk);
        w++;
      end
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    tx_valid = 1'h0;
    w = 0;
    while ((mii_tx_en || emf_phy_model_i.txq.size() == 0) && w < 2000) begin
      @(negedge ref_clk);
      w++;
    end
    check("tx underrun", cut, und_cnt - u0);
    check("tx nibbles", e.size(), emf_phy_model_i.txq.size());
    foreach (e[i]) if (i < emf_phy_model_i.txq.size())
      check("tx nibble", e[i], emf_phy_model_i.txq[i]);
  endtask
  task automatic t_rx(input logic grp, input logic bad);
    logic [7:0] b[$];
    logic [3:0] n[$];
    logic [31:0] c;
    int d0, w;
    c = CRC_INIT;
    for (int i = 0; i < 20; i++) b.push_back(i == 0 ? {7'h01, grp} : 8'(i * 3 + 64));
    foreach (b[i]) c = crc_nib(crc_nib(c, b[i][3:0]), b[i][7:4]);
    for (int j = 0; j < 4; j++) b.push_back(~c[8*j+:8] ^ {7'h00, bad});
    n = '{4'h3, 4'h5, 4'h7};
    for (int i = 0; i < 15; i++) n.push_back(PRE_NIBBLE);
    n.push_back(SFD_HI_NIBBLE);
    foreach (b[i]) begin
      n.push_back(b[i][3:0]);
      n.push_back(b[i][7:4]);
    end
    rxq.delete();
    first_at = -1;
    d0 = done_cnt;
    emf_phy_model_i.send(n);
    w = 0;
    while (done_cnt == d0 && w < 100) begin
      @(negedge ref_clk);
      w++;
    end
    check("rx done", d0 + 1, done_cnt);
    check("rx bytes", b.size(), rxq.size());
    foreach (b[i]) if (i < rxq.size()) check("rx byte", b[i], rxq[i]);
    check("rx first", 0, first_at);
    check("rx group", grp, rx_group);
    check("rx crc ok", !bad, crc_seen);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    reset_n = 1'h0;
    tx_valid = 1'h0;
    tx_data = 8'h00;
    tx_last = 1'h0;
    pad_enable = 1'h0;
    alternate_function_select = 2'h0;
    gpio_out = 2'h2;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'h1;
    t_ind();
    t_tx(20, 1'h1, 1'h0);
    t_tx(20, 1'h0, 1'h0);
    t_tx(60, 1'h1, 1'h0);
    t_tx(3, 1'h1, 1'h1);
    t_rx(1'h1, 1'h0);
    t_rx(1'h0, 1'h1);
    end_of_test();
  end
endmodule // emf_mac_framing_tb
`default_nettype wire

/* emf_phy_model.sv */
// Purpose: physical layer stand-in on the nibble link
// Assumes: link slot ticks every fourth ref_clk edge after reset release
// Notes:   receive nibble shows the inverse of its last value while idle
`timescale 1ns/1ns
`default_nettype none
module emf_phy_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // nibble link
  input  wire logic [3:0] mii_txd,
  input  wire logic       mii_tx_en,
  output var  logic [3:0] mii_rxd,
  output var  logic       mii_rx_dv
);
  logic [1:0] div;
  logic [3:0] txq[$];
  initial begin
    mii_rxd = 4'ha;
    mii_rx_dv = 1'h0;
  end
  // 25 MHz slot divider; captures transmit nibbles once per slot
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 2'h0;
    end else begin
      if (div == 2'h3 && mii_tx_en) txq.push_back(mii_txd);
      div <= div + 2'h1;
    end
  end
  // one nibble per slot, then release the valid line
  task automatic send(input logic [3:0] n[$]);
    foreach (n[i]) begin
      @(negedge ref_clk);
      while (div != 2'h0) @(negedge ref_clk);
      mii_rx_dv = 1'h1;
      mii_rxd = n[i];
    end
    @(negedge ref_clk);
    while (div != 2'h0) @(negedge ref_clk);
    mii_rx_dv = 1'h0;
    mii_rxd = ~mii_rxd;
  endtask
endmodule // emf_phy_model
`default_nettype wire

/* emf_pkg.sv */
// Purpose: shared constants for the ethernet mac framing front end
// Assumes: 100 MHz ref_clk, nibble-wide media independent link at 25 MHz
// Notes:   crc constants follow the reflected crc-32 form, shifted lsb first
package emf_pkg;
  // clocking: the link runs at one nibble per enable pulse
  localparam int unsigned REF_CLK_HZ   = 100_000_000;
  localparam int unsigned LINK_CLK_HZ  = 25_000_000;
  localparam int unsigned TICK_DIV     = REF_CLK_HZ / LINK_CLK_HZ;
  localparam logic [1:0]  TICK_LAST    = 2'(TICK_DIV - 1);

  // frame layout
  localparam logic [2:0]  PREAMBLE_LAST = 3'h6;        // seven octets, counted 0..6
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;       // alternating one-zero on the line
  localparam logic [7:0]  SFD_BYTE      = 8'hd5;       // 1010.1011 in line order
  localparam logic [3:0]  PRE_NIBBLE    = 4'h5;
  localparam logic [3:0]  SFD_HI_NIBBLE = 4'hd;
  localparam int unsigned HEADER_OCTETS = 14;          // destination, source, length/type
  localparam int unsigned DATA_MIN      = 46;
  localparam logic [10:0] MIN_BODY      = 11'(HEADER_OCTETS + DATA_MIN);
  localparam logic [2:0]  FCS_LAST_NIB  = 3'h7;        // four octets, eight nibbles

  // crc-32
  localparam logic [31:0] CRC_POLY      = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT      = 32'hffff_ffff;
  localparam logic [31:0] CRC_RESIDUE   = 32'hdebb_20e3;

  // reset values of the indicator pins
  localparam logic [1:0]  IND_RESET     = 2'h0;

  // transmit and receive states
  typedef enum logic [5:0] {
    EMF_TX_IDLE = 6'b00_0001,
    EMF_TX_PRE  = 6'b00_0010,
    EMF_TX_SFD  = 6'b00_0100,
    EMF_TX_BODY = 6'b00_1000,
    EMF_TX_PAD  = 6'b01_0000,
    EMF_TX_FCS  = 6'b10_0000
  } emf_tx_state_t;

  typedef enum logic [2:0] {
    EMF_RX_HUNT = 3'b001,
    EMF_RX_PRE  = 3'b010,
    EMF_RX_DATA = 3'b100
  } emf_rx_state_t;
endpackage
